// ==== hdl/plcr_delay.sv ====
// Delay counter that releases an upstream retrain after a fixed wait
module plcr_delay #(
  parameter int unsigned DELAY_CYCLES = 40000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  import plcr_pkg::*;
  logic [PLCR_CNT_W-1:0] count;

  // A new start while busy restarts the wait so the latest write still gets its full delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= PLCR_CNT_W'(DELAY_CYCLES - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - PLCR_CNT_W'(1);
        end
      end
    end
  end
endmodule : plcr_delay

// ==== hdl/plcr_pkg.sv ====
// Constants shared by the port link control register block
package plcr_pkg;
  localparam logic [11:0] PLCR_LINK_CONTROL_OFFSET = 12'h050;
  localparam logic [11:0] PLCR_LINK_STATUS_OFFSET = 12'h052;
  localparam int PLCR_ASPM_LO = 0;
  localparam int PLCR_RESERVED_BIT = 2;
  localparam int PLCR_RCB_BIT = 3;
  localparam int PLCR_LINK_DISABLE_BIT = 4;
  localparam int PLCR_RETRAIN_BIT = 5;
  localparam int PLCR_COMMON_CLOCK_BIT = 6;
  localparam int PLCR_LINK_TRAINING_BIT = 11;
  localparam logic [1:0] PLCR_ASPM_RESET = 2'h0;
  localparam logic [1:0] PLCR_ASPM_L0S = 2'h1;
  localparam logic [1:0] PLCR_ASPM_L1 = 2'h2;
  localparam logic [1:0] PLCR_ASPM_BOTH = 2'h3;
  localparam int PLCR_CLK_HZ = 40_000_000;
  localparam int PLCR_UP_DELAY_US = 1000;
  localparam int PLCR_UP_DELAY_CYCLES = PLCR_CLK_HZ / 1_000_000 * PLCR_UP_DELAY_US;
  localparam int PLCR_CNT_W = 16;
  typedef enum logic [1:0] {
    PLCR_IDLE = 2'b00,
    PLCR_WAIT = 2'b01,
    PLCR_FIRE = 2'b11
  } plcr_state_e;
endpackage : plcr_pkg

// ==== hdl/plcr_top.sv ====
// Port link control register with retrain sequencing toward the link training state machine
module plcr_top #(
  parameter int unsigned UP_DELAY_CYCLES = plcr_pkg::PLCR_UP_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Port strapping and switch control
  input wire logic is_upstream,
  input wire logic register_unlock_bit,
  // Serial EEPROM initialization
  input wire logic eeprom_load,
  input wire logic [1:0] eeprom_aspm,
  // Configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  // Training state machine interface
  input wire logic ltssm_in_recovery,
  input wire logic ltssm_in_config,
  input wire logic ltssm_training_done,
  output logic retrain_req,
  output logic link_disable,
  output logic tx_l0s_enable,
  output logic l1_enable,
  output logic common_clock,
  output logic link_training_flag
);
  import plcr_pkg::*;

  // Reset copy
  logic rst_meta;
  logic rst_sync_n;
  // Software visible fields and their next values
  logic [1:0] aspm;
  logic link_disable_bit;
  logic common_clock_bit;
  logic [1:0] next_aspm;
  logic next_link_disable_bit;
  logic next_common_clock_bit;
  // Settings as applied to the link
  logic [1:0] applied_aspm;
  logic applied_common_clock;
  logic pending_apply;
  // Access decode
  logic ctl_write;
  logic ctl_read;
  logic sts_read;
  // Retrain sequencing
  logic retrain_allowed;
  logic retrain_hit;
  logic in_training;
  logic training_over;
  logic up_start;
  logic up_busy;
  logic up_done;
  logic up_fire;
  logic fire;
  plcr_state_e up_state;
  plcr_state_e next_up_state;
  // Read views
  logic [15:0] ctl_view;
  logic [15:0] sts_view;
  logic [15:0] next_rdata;

  // Offset match shared by the write and read decodes
  function automatic logic plcr_addr_hit(input logic [11:0] addr, input logic [11:0] offset);
    return addr == offset;
  endfunction : plcr_addr_hit

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Access decode; every used control bit lives in the low byte
  assign ctl_write = cfg_wr && cfg_be[0] && plcr_addr_hit(cfg_addr, PLCR_LINK_CONTROL_OFFSET);
  assign ctl_read = cfg_rd && plcr_addr_hit(cfg_addr, PLCR_LINK_CONTROL_OFFSET);
  assign sts_read = cfg_rd && plcr_addr_hit(cfg_addr, PLCR_LINK_STATUS_OFFSET);

  // Retrain decode; a locked upstream port ignores the request bit entirely
  assign in_training = ltssm_in_recovery || ltssm_in_config;
  assign training_over = pending_apply && ltssm_training_done && !in_training;
  assign retrain_allowed = !is_upstream || register_unlock_bit;
  assign retrain_hit = ctl_write && cfg_wdata[PLCR_RETRAIN_BIT] && retrain_allowed;
  assign up_start = retrain_hit && is_upstream;
  assign up_fire = (up_state == PLCR_WAIT) && up_done;
  assign fire = (retrain_hit && !is_upstream) || up_fire;

  // Next field values; a configuration write wins over a concurrent EEPROM load
  always_comb begin
    next_aspm = aspm;
    next_link_disable_bit = link_disable_bit;
    next_common_clock_bit = common_clock_bit;
    if (ctl_write) begin
      next_aspm = cfg_wdata[PLCR_ASPM_LO +: 2];
      next_link_disable_bit = cfg_wdata[PLCR_LINK_DISABLE_BIT];
      next_common_clock_bit = cfg_wdata[PLCR_COMMON_CLOCK_BIT];
    end else if (eeprom_load) begin
      next_aspm = eeprom_aspm;
    end
  end

  // Power management field
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aspm <= PLCR_ASPM_RESET;
    end else begin
      aspm <= next_aspm;
    end
  end

  // Link disable field
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_disable_bit <= 1'b0;
    end else begin
      link_disable_bit <= next_link_disable_bit;
    end
  end

  // Common clock field
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      common_clock_bit <= 1'b0;
    end else begin
      common_clock_bit <= next_common_clock_bit;
    end
  end

  // Training related settings; next values are used so a retrain write applies its own fields
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      applied_aspm <= PLCR_ASPM_RESET;
      applied_common_clock <= 1'b0;
      pending_apply <= 1'b0;
    end else if (fire && in_training) begin
      pending_apply <= 1'b1;
    end else if (fire || training_over) begin
      applied_aspm <= next_aspm;
      applied_common_clock <= next_common_clock_bit;
      pending_apply <= 1'b0;
    end else if ((ctl_write || eeprom_load) && !in_training) begin
      applied_aspm <= next_aspm;
      applied_common_clock <= next_common_clock_bit;
    end
  end

  // Upstream retrain: wait out the delay, then hand one request to the link
  always_comb begin
    next_up_state = up_state;
    unique case (up_state)
      PLCR_IDLE: begin
        if (up_start) begin
          next_up_state = PLCR_WAIT;
        end
      end
      PLCR_WAIT: begin
        if (up_done) begin
          next_up_state = PLCR_FIRE;
        end else if (!up_busy && !up_start) begin
          next_up_state = PLCR_IDLE;
        end
      end
      PLCR_FIRE: begin
        // A restart landing on the release edge must not be lost
        if (up_start || up_busy) begin
          next_up_state = PLCR_WAIT;
        end else begin
          next_up_state = PLCR_IDLE;
        end
      end
      default: begin
        next_up_state = PLCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      up_state <= PLCR_IDLE;
    end else begin
      up_state <= next_up_state;
    end
  end

  // Upstream retrain waits so the write's completion leaves first
  plcr_delay #(
    .DELAY_CYCLES(UP_DELAY_CYCLES)
  ) u_delay (
    .clk(clk),
    .rst_n(rst_sync_n),
    .start(up_start),
    .busy(up_busy),
    .done(up_done)
  );

  // Retrain request pulse toward the training state machine
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      retrain_req <= 1'b0;
    end else begin
      retrain_req <= fire;
    end
  end

  // Settings toward the link, all registered
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_disable <= 1'b0;
      tx_l0s_enable <= 1'b0;
      l1_enable <= 1'b0;
      common_clock <= 1'b0;
    end else begin
      link_disable <= link_disable_bit && !is_upstream;
      tx_l0s_enable <= applied_aspm[0];
      l1_enable <= applied_aspm[1];
      common_clock <= applied_common_clock;
    end
  end

  // Training flag: set on the request actually reaching the link, cleared when training ends
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_training_flag <= 1'b0;
    end else if (fire) begin
      link_training_flag <= 1'b1;
    end else if (ltssm_training_done) begin
      link_training_flag <= 1'b0;
    end
  end

  // Control view; constant bits never hold state
  always_comb begin
    ctl_view = '0;
    ctl_view[PLCR_ASPM_LO +: 2] = aspm;
    ctl_view[PLCR_RESERVED_BIT] = 1'b0;
    ctl_view[PLCR_RCB_BIT] = 1'b0;
    ctl_view[PLCR_LINK_DISABLE_BIT] = link_disable_bit;
    ctl_view[PLCR_RETRAIN_BIT] = 1'b0;
    ctl_view[PLCR_COMMON_CLOCK_BIT] = common_clock_bit;
  end

  always_comb begin
    sts_view = '0;
    sts_view[PLCR_LINK_TRAINING_BIT] = link_training_flag;
  end

  // Unmapped offsets return zero
  always_comb begin
    next_rdata = '0;
    if (ctl_read) begin
      next_rdata = ctl_view;
    end else if (sts_read) begin
      next_rdata = sts_view;
    end
  end

  // Read data registered and held until the next read
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_rdata <= '0;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= next_rdata;
      end
    end
  end
endmodule : plcr_top

// ==== testbench/plcr_ltssm_model.sv ====
// Behavioural training state machine at the far end of the link
module plcr_ltssm_model (
  // Clock, pace and state
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic retrain_req,
  output logic ltssm_in_recovery,
  output logic ltssm_in_config,
  output logic ltssm_training_done
);
  logic [4:0] cnt;
  // A new request restarts training, as a real partner re-enters Recovery
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 5'h00;
    else if (retrain_req) cnt <= slow ? 5'h1F : 5'h06;
    else if (cnt != 5'h00) cnt <= cnt - 5'h01;
  end
  assign ltssm_in_recovery = cnt > 5'h03;
  assign ltssm_in_config = cnt inside {5'h02, 5'h03};
  assign ltssm_training_done = cnt == 5'h01;
endmodule : plcr_ltssm_model

// ==== testbench/plcr_sva.sv ====
// Port-level assertions of the link control register
module plcr_sva
  import plcr_pkg::*;
#(parameter int unsigned UP_DELAY_CYCLES = 10) (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic is_upstream,
  input wire logic register_unlock_bit,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic ltssm_in_recovery,
  input wire logic ltssm_in_config,
  input wire logic retrain_req,
  input wire logic link_disable,
  input wire logic tx_l0s_enable,
  input wire logic l1_enable,
  input wire logic common_clock,
  input wire logic link_training_flag
);
  localparam int FIRE = UP_DELAY_CYCLES + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Control write while the link is not training
  sequence s_wr;
    cfg_wr && cfg_addr == PLCR_LINK_CONTROL_OFFSET && cfg_be[0] && !ltssm_in_recovery && !ltssm_in_config;
  endsequence
  sequence s_up_rt;
    s_wr ##0 cfg_wdata[5] && is_upstream && register_unlock_bit;
  endsequence
  AST_RCB_ZERO: assert property (cfg_rvalid |-> !cfg_rdata[3]) else $error("bit 3 set");
  AST_RET_ZERO: assert property (cfg_rvalid |-> !cfg_rdata[5]) else $error("bit 5 set");
  AST_UP_NO_DIS: assert property (is_upstream |-> !link_disable) else $error("upstream disabled");
  AST_UP_LOCKED: assert property (is_upstream && !register_unlock_bit |-> !retrain_req) else $error("locked");
  AST_DN_RETRAIN: assert property (s_wr ##0 cfg_wdata[5] && !is_upstream |=>
    retrain_req && link_training_flag) else $error("no retrain");
  AST_UP_QUIET: assert property (s_up_rt |=> (!retrain_req && !link_training_flag) [*8]) else $error("early");
  AST_UP_FIRE: assert property (s_up_rt |-> ##FIRE retrain_req && link_training_flag) else $error("late");
  AST_APPLY: assert property (s_wr |-> ##2
    tx_l0s_enable == $past(cfg_wdata[0], 2) && l1_enable == $past(cfg_wdata[1], 2)
    && common_clock == $past(cfg_wdata[6], 2)
    && link_disable == ($past(cfg_wdata[4], 2) && !$past(is_upstream, 2))) else $error("not applied");
endmodule : plcr_sva

bind plcr_top plcr_sva #(.UP_DELAY_CYCLES(UP_DELAY_CYCLES)) u_sva (.*);

// ==== testbench/port_link_control_register_tb_top.sv ====
// Self-checking bench of the port link control register
module port_link_control_register_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import plcr_pkg::*;
  localparam logic [11:0] CTL = PLCR_LINK_CONTROL_OFFSET;
  localparam logic [11:0] STS = PLCR_LINK_STATUS_OFFSET;
  logic clk = 1'b0, rst_n = 1'b0, is_upstream = 1'b0, register_unlock_bit = 1'b0, slow = 1'b0;
  logic eeprom_load = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_rvalid, retrain_req, link_disable;
  logic ltssm_in_recovery, ltssm_in_config, ltssm_training_done, tx_l0s_enable, l1_enable;
  logic common_clock, link_training_flag;
  logic [1:0] eeprom_aspm = 2'h2, cfg_be = 2'h3;
  logic [11:0] cfg_addr = 12'h000;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, d, exp_q[$];
  int fails = 0, num_checks = 0, seed = 32'hEC229859;
  always #12.5 clk = ~clk;
  plcr_top #(.UP_DELAY_CYCLES(10)) u_dut (.*);
  plcr_ltssm_model u_ltssm (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, got, want);
    end
  endtask : chk
  // Two cycles per access so no strobe is driven twice in one time step
  task automatic acc(input logic wr, input logic [11:0] a, input logic [15:0] v);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {wr, !wr, a, v};
    if (!wr) exp_q.push_back(v);
    @(posedge clk);
    {cfg_wr, cfg_rd} <= 2'h0;
    @(posedge clk);
  endtask : acc
  task automatic settle();
    for (int n = 0; n < 99 && ltssm_training_done !== 1'b1; n++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  always @(posedge clk) if (cfg_rvalid === 1'b1) chk(cfg_rdata, exp_q.pop_front());
  initial begin
    #75000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, CTL, 16'h0000);
    acc(1'b0, 12'h100, 16'h0000);
    eeprom_load <= 1'b1;
    @(posedge clk);
    eeprom_load <= 1'b0;
    acc(1'b0, CTL, 16'h0002);
    for (int v = 0; v < 4; v++) begin
      d = 16'($random(seed)) & 16'h005C | 16'(v);
      acc(1'b1, CTL, d);
      @(posedge clk);
      chk({14'h0000, l1_enable, tx_l0s_enable}, d & 16'h0003);
      acc(1'b0, CTL, d & 16'h0053);
    end
    acc(1'b1, CTL, 16'h0033);
    @(posedge clk);
    chk({15'h0000, link_disable}, 16'h0001);
    acc(1'b0, STS, 16'h0800);
    settle();
    slow <= 1'b1;
    acc(1'b1, CTL, 16'h0021);
    repeat (2) @(posedge clk);
    acc(1'b1, CTL, 16'h0022);
    chk({14'h0000, l1_enable, tx_l0s_enable}, 16'h0001);
    settle();
    chk({14'h0000, l1_enable, tx_l0s_enable}, 16'h0002);
    {slow, is_upstream} <= 2'h1;
    acc(1'b1, CTL, 16'h0030);
    repeat (20) @(posedge clk);
    acc(1'b0, STS, 16'h0000);
    register_unlock_bit <= 1'b1;
    acc(1'b1, CTL, 16'h0020);
    acc(1'b0, STS, 16'h0000);
    repeat (10) @(posedge clk);
    acc(1'b0, STS, 16'h0800);
    settle();
    wrap_up();
  end
endmodule : port_link_control_register_tb_top
